// *** design/cmptmr_defs.vh ***
// register offsets, field positions and reset values of the compare timer
// assumes word-wide register port with byte offsets as printed
`ifndef CMPTMR_DEFS_VH
`define CMPTMR_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define CMPTMR_OFS_CMPA    16'h5300
`define CMPTMR_OFS_CMPB    16'h5302
`define CMPTMR_OFS_COUNT   16'h5304
`define CMPTMR_OFS_CTRL    16'h5306
`define CMPTMR_OFS_CLOCK_SOURCE_SELECT  16'h5308
`define CMPTMR_OFS_INTEN   16'h530A

// ****************************************
// control field positions
// ****************************************
`define CMPTMR_CTL_RUN     0
`define CMPTMR_CTL_CLEAR   1
`define CMPTMR_CTL_SRC     3
`define CMPTMR_CTL_BUFEN   5
`define CMPTMR_INT_A       0
`define CMPTMR_INT_B       1

// ****************************************
// reset values and codes
// ****************************************
`define CMPTMR_ZERO16      16'h0000
`define CMPTMR_DIV_RST     4'h0
`define CMPTMR_DIV_RSVD    4'hF
`define CMPTMR_DIV_MAX     4'hE
`define CMPTMR_DIV_MSB     3
`define CMPTMR_INT_MSB     1
`define CMPTMR_CODES       16
`define CMPTMR_ONE16       16'h0001

`endif

// *** design/cmptmr_top.v ***
// one channel of a 16-bit compare timer with match outputs
// assumes a single 20 MHz clock and a simple strobe register port
//
// Operation
// RULE1 - 16-bit up-counter, software clearable, loadable and readable anytime.
// RULE2 - control bit 3 picks internal prescaler (0) or external events (1).
// RULE3 - 4-bit divider code n selects clock divided by 2^n; 0xF reserved.
// RULE4 - external mode counts rising edges of the external input, no prescaler.
// RULE5 - writing 1 to control bit 1 clears the counter.
// RULE6 - writing the counter register loads that value.
// RULE7 - match on B flags cause B and restarts the count from zero.
// RULE8 - match on A flags cause A and leaves the count alone.
// RULE9 - control bit 5 routes compare accesses to shadow buffers.
// RULE10 - with buffering, buffers load active compares on every counter reset.
// RULE11 - with buffering, compare addresses read and write the buffers.
// RULE12 - active compares and buffers are zero after reset.
// RULE13 - match signals also drive the timer output logic.
// RULE14 - wrap period is compare B plus one count periods.
// RULE15 - control bit 0 runs the counter when 1, stops it when 0.
// RULE16 - starting or stopping keeps the counter value.
// RULE17 - run and clear in one write clear first, then count.
// RULE18 - counting goes on whatever match cause occurred.
// RULE19 - an enabled match cause raises the interrupt request.
// RULE20 - software runs prescaler first, changes clock only while stopped.
// RULE21 - software selects the external input pin function first.
// RULE22 - software configures source, output, interrupt, counter, compares in order.
// RULE23 - external input is synchronised and edge detected into one pulse.
`timescale 1ns/1ps
`include "cmptmr_defs.vh"

module cmptmr_top #(
    parameter DIV_W = 14
) (
    // clock, reset, enable
    input  wire        REF_CLK,
    input  wire        RESET,
    input  wire        CLK_EN,
    // register port
    input  wire [15:0] ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [15:0] RDATA,
    // external count input pin
    input  wire        EXT_COUNT_IN,
    // match and interrupt outputs
    output reg         MATCH_A,
    output reg         MATCH_B,
    output reg         IRQ
);

    // ****************************************
    // registers
    // ****************************************
    reg  [15:0]      count_q;
    reg  [15:0]      cmpa_q;
    reg  [15:0]      cmpb_q;
    reg  [15:0]      bufa_q;
    reg  [15:0]      bufb_q;
    reg              run_q;
    reg              src_q;
    reg              bufen_q;
    reg  [3:0]       div_q;
    reg  [1:0]       inten_q;
    reg  [DIV_W-1:0] pre_q;
    reg  [2:0]       sync_q;
    reg              ext_lvl_q;

    // ****************************************
    // address decode
    // ****************************************
    // one select line per mapped word; unmapped addresses hit none
    wire sel_cmpa   = (ADDR == `CMPTMR_OFS_CMPA);
    wire sel_cmpb   = (ADDR == `CMPTMR_OFS_CMPB);
    wire sel_count  = (ADDR == `CMPTMR_OFS_COUNT);
    wire sel_ctrl   = (ADDR == `CMPTMR_OFS_CTRL);
    wire sel_clock_source_select = (ADDR == `CMPTMR_OFS_CLOCK_SOURCE_SELECT);
    wire sel_inten  = (ADDR == `CMPTMR_OFS_INTEN);

    // write strobes qualified by the select lines
    wire wr_cmpa   = WR && sel_cmpa;
    wire wr_cmpb   = WR && sel_cmpb;
    wire wr_count  = WR && sel_count;
    wire wr_ctrl   = WR && sel_ctrl;
    wire wr_clock_source_select = WR && sel_clock_source_select;
    wire wr_inten  = WR && sel_inten;

    // clear bit is a one-shot action, never stored
    // RULE5 software clear
    wire sw_clear = wr_ctrl && WDATA[`CMPTMR_CTL_CLEAR];

    // ****************************************
    // count enable generation
    // ****************************************
    // RULE23 sync and edge
    always @(posedge REF_CLK) begin
        if (RESET) begin
            sync_q    <= 3'h0;
            ext_lvl_q <= 1'b0;
        end else if (CLK_EN) begin
            sync_q <= {sync_q[1:0], EXT_COUNT_IN};
            if (sync_q[1] == sync_q[2]) begin
                ext_lvl_q <= sync_q[2];
            end
        end
    end
    wire ext_rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !ext_lvl_q;

    // free-running prescaler chain; tap n toggles every 2^n cycles
    always @(posedge REF_CLK) begin
        if (RESET) begin
            pre_q <= {DIV_W{1'b0}};
        end else if (CLK_EN) begin
            pre_q <= pre_q + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************
    // divider tap select
    // ****************************************
    // tap n fires when the low n prescaler bits are all zero,
    // so once every 2^n clocks; taps beyond the chain never fire
    wire [`CMPTMR_CODES-1:0] tap_hit;
    assign tap_hit[0] = 1'b1;
    genvar gi;
    generate
        for (gi = 1; gi < `CMPTMR_CODES; gi = gi + 1) begin : g_tap
            if (gi <= DIV_W) begin : g_live
                assign tap_hit[gi] = (pre_q[gi-1:0] == {gi{1'b0}});
            end else begin : g_dead
                assign tap_hit[gi] = 1'b0;
            end
        end
    endgenerate

    // the reserved code gives no ticks at all, so the counter stalls
    // RULE3 divider tap
    reg int_tick;
    always @* begin
        int_tick = 1'b0;
        if (div_q <= `CMPTMR_DIV_MAX) begin
            int_tick = tap_hit[div_q];
        end
    end

    // RULE2 source select, RULE4 external edge, RULE15 run gate
    wire tick = run_q && (src_q ? ext_rise : int_tick);

    // RULE7 B match, RULE8 A match
    wire hit_a = tick && (count_q == cmpa_q);
    wire hit_b = tick && (count_q == cmpb_q);
    // RULE10 load on any counter reset
    wire ctr_reset = sw_clear || hit_b;

    // ****************************************
    // counter
    // ****************************************
    always @(posedge REF_CLK) begin
        if (RESET) begin
            count_q <= `CMPTMR_ZERO16;
        end else if (CLK_EN) begin
            // RULE5 RULE17 clear beats count
            if (sw_clear) begin
                count_q <= `CMPTMR_ZERO16;
            // RULE6 software load
            end else if (wr_count) begin
                count_q <= WDATA;
            // RULE7 RULE14 wrap after B
            end else if (hit_b) begin
                count_q <= `CMPTMR_ZERO16;
            // RULE1 RULE16 RULE18 count up
            end else if (tick) begin
                count_q <= count_q + `CMPTMR_ONE16;
            end
        end
    end

    // ****************************************
    // compare registers and buffers
    // ****************************************
    // buffered mode steers compare writes to the shadow words
    wire wr_bufa  = wr_cmpa && bufen_q;
    wire wr_bufb  = wr_cmpb && bufen_q;
    wire wr_acta  = wr_cmpa && !bufen_q;
    wire wr_actb  = wr_cmpb && !bufen_q;
    // with buffering on, shadow words move into the active compares on any counter reset
    // RULE10 buffer transfer
    wire xfer_buf = bufen_q && ctr_reset;

    // ****************************************
    // shadow buffers
    // ****************************************
    // shadow word for compare A
    // RULE9 RULE11 RULE12 buffered writes
    always @(posedge REF_CLK) begin
        if (RESET) begin
            bufa_q <= `CMPTMR_ZERO16;
        end else if (CLK_EN) begin
            if (wr_bufa) begin
                bufa_q <= WDATA;
            end
        end
    end

    // shadow word for compare B
    // RULE9 RULE11 RULE12 buffered writes
    always @(posedge REF_CLK) begin
        if (RESET) begin
            bufb_q <= `CMPTMR_ZERO16;
        end else if (CLK_EN) begin
            if (wr_bufb) begin
                bufb_q <= WDATA;
            end
        end
    end

    // ****************************************
    // active compares
    // ****************************************
    // active compare A; a transfer wins over a direct write
    // RULE12 reset zero
    always @(posedge REF_CLK) begin
        if (RESET) begin
            cmpa_q <= `CMPTMR_ZERO16;
        end else if (CLK_EN) begin
            if (xfer_buf) begin
                cmpa_q <= bufa_q;
            end else if (wr_acta) begin
                cmpa_q <= WDATA;
            end
        end
    end

    // active compare B; a transfer wins over a direct write
    // RULE12 reset zero
    always @(posedge REF_CLK) begin
        if (RESET) begin
            cmpb_q <= `CMPTMR_ZERO16;
        end else if (CLK_EN) begin
            if (xfer_buf) begin
                cmpb_q <= bufb_q;
            end else if (wr_actb) begin
                cmpb_q <= WDATA;
            end
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // run flag; stopping only gates ticks, the count is kept
    // RULE15 run bit
    always @(posedge REF_CLK) begin
        if (RESET) begin
            run_q <= 1'b0;
        end else if (CLK_EN) begin
            if (wr_ctrl) begin
                run_q <= WDATA[`CMPTMR_CTL_RUN];
            end
        end
    end

    // count source; software changes it only while stopped
    // RULE2 source select
    always @(posedge REF_CLK) begin
        if (RESET) begin
            src_q <= 1'b0;
        end else if (CLK_EN) begin
            if (wr_ctrl) begin
                src_q <= WDATA[`CMPTMR_CTL_SRC];
            end
        end
    end

    // buffer enable for compare accesses
    // RULE9 buffer enable
    always @(posedge REF_CLK) begin
        if (RESET) begin
            bufen_q <= 1'b0;
        end else if (CLK_EN) begin
            if (wr_ctrl) begin
                bufen_q <= WDATA[`CMPTMR_CTL_BUFEN];
            end
        end
    end

    // ****************************************
    // divider code and request enables
    // ****************************************
    // divider code; the reserved code is kept and then gives no ticks
    // RULE3 divider code
    always @(posedge REF_CLK) begin
        if (RESET) begin
            div_q <= `CMPTMR_DIV_RST;
        end else if (CLK_EN) begin
            if (wr_clock_source_select) begin
                div_q <= WDATA[`CMPTMR_DIV_MSB:0];
            end
        end
    end

    // request enables, one per match cause
    // RULE19 cause enables
    always @(posedge REF_CLK) begin
        if (RESET) begin
            inten_q <= 2'h0;
        end else if (CLK_EN) begin
            if (wr_inten) begin
                inten_q <= WDATA[`CMPTMR_INT_MSB:0];
            end
        end
    end

    // ****************************************
    // outputs and read port
    // ****************************************
    // match pulses, one clock per counted tick on a match
    // RULE13 match pulses out
    always @(posedge REF_CLK) begin
        if (RESET) begin
            MATCH_A <= 1'b0;
            MATCH_B <= 1'b0;
        end else if (CLK_EN) begin
            MATCH_A <= hit_a;
            MATCH_B <= hit_b;
        end
    end

    // request pulse for the interrupt controller; no flags kept here
    wire irq_d = (hit_a && inten_q[`CMPTMR_INT_A]) || (hit_b && inten_q[`CMPTMR_INT_B]);

    // RULE19 enabled cause request
    always @(posedge REF_CLK) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else if (CLK_EN) begin
            IRQ <= irq_d;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    // readback words; the clear bit is write-only and reads zero
    wire [15:0] ctrl_rd   = {10'h000, bufen_q, 1'b0, src_q, 2'h0, run_q};
    wire [15:0] clock_source_select_rd = {12'h000, div_q};
    wire [15:0] inten_rd  = {14'h0000, inten_q};

    // read mux; buffered mode shows the shadow words
    // RULE11 buffered reads
    reg [15:0] rd_mux;
    always @* begin
        rd_mux = `CMPTMR_ZERO16;
        case (ADDR)
            `CMPTMR_OFS_CMPA:   rd_mux = bufen_q ? bufa_q : cmpa_q;
            `CMPTMR_OFS_CMPB:   rd_mux = bufen_q ? bufb_q : cmpb_q;
            `CMPTMR_OFS_COUNT:  rd_mux = count_q;
            `CMPTMR_OFS_CTRL:   rd_mux = ctrl_rd;
            `CMPTMR_OFS_CLOCK_SOURCE_SELECT: rd_mux = clock_source_select_rd;
            `CMPTMR_OFS_INTEN:  rd_mux = inten_rd;
            default:            rd_mux = `CMPTMR_ZERO16;
        endcase
    end

    // read data stand for the one clock after the strobe, else zero
    // RULE1 readable anytime
    always @(posedge REF_CLK) begin
        if (RESET) begin
            RDATA <= `CMPTMR_ZERO16;
        end else if (CLK_EN) begin
            if (RD) begin
                RDATA <= rd_mux;
            end else begin
                RDATA <= `CMPTMR_ZERO16;
            end
        end
    end

endmodule

// *** dv/cmptmr_chk.sv ***
// checker of the compare timer ports
// assumes cmptmr_top as the bound target
`timescale 1ns/1ps
module cmptmr_chk #(parameter DIV_W = 14) (
    // all ports of the timer, seen as inputs
    input wire        REF_CLK, RESET, CLK_EN, WR, RD, EXT_COUNT_IN, MATCH_A, MATCH_B, IRQ,
    input wire [15:0] ADDR, WDATA, RDATA
);
    reg  run_q;
    wire we = CLK_EN && WR;
    // run bit as last written
    always @(posedge REF_CLK) begin
        if (RESET)
            run_q <= 1'b0;
        else if (we && ADDR == 16'h5306)
            run_q <= WDATA[0];
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    a_rd_idle:
    assert property ($past(CLK_EN) && !$past(RD) |-> RDATA == 16'h0000) else $error("rdata");
    a_reset_quiet:
    assert property ($past(RESET) |-> !MATCH_A && !MATCH_B && !IRQ) else $error("reset");
    a_irq_cause:
    assert property (IRQ |-> MATCH_A || MATCH_B) else $error("irq");
    a_stop_quiet:
    assert property (!run_q && !$past(run_q) && !$past(run_q, 2) |-> !MATCH_A && !MATCH_B)
        else $error("stopped");
    a_load_read:
    assert property (we && ADDR == 16'h5304 && !run_q ##1 RD && ADDR == 16'h5304
        |=> RDATA == $past(WDATA, 2)) else $error("load");
    a_clear_read:
    assert property (we && ADDR == 16'h5306 && WDATA[1:0] == 2'h2 ##1 RD && ADDR == 16'h5304
        |=> RDATA == 16'h0000) else $error("clear");
    a_ctl_read:
    assert property (RD && ADDR == 16'h5306 |=> !RDATA[1]) else $error("ctl");
    a_cmp_read:
    assert property (we && ADDR == 16'h5302 ##1 RD && ADDR == 16'h5302
        |=> RDATA == $past(WDATA, 2)) else $error("cmp");
endmodule
bind cmptmr_top cmptmr_chk #(.DIV_W(DIV_W)) chk_u (.REF_CLK(REF_CLK), .RESET(RESET),
    .CLK_EN(CLK_EN), .WR(WR), .RD(RD), .EXT_COUNT_IN(EXT_COUNT_IN), .MATCH_A(MATCH_A),
    .MATCH_B(MATCH_B), .IRQ(IRQ), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA));

// *** dv/cmptmr_src.sv ***
// far side: event pin source and interrupt request counter
// assumes one clock; the pin idles low outside pulses
`timescale 1ns/1ps
module cmptmr_src (
    input wire logic    clk, irq,
    output logic        pin = 1'b0,
    output logic [15:0] irq_cnt = 16'h0000
);
    always @(posedge clk)
        if (irq === 1'b1)
            irq_cnt <= irq_cnt + 16'h0001;
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            pin <= 1'b1;
            repeat (4) @(posedge clk);
            pin <= 1'b0;
        end
    endtask
endmodule

// *** dv/cmptmr_top_tb.sv ***
// self-checking bench of the compare timer
// assumes cmptmr_src as far side and the bound checker
`timescale 1ns/1ps
module cmptmr_top_tb;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, en = 1'b1, ext, ma, mb, irq;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, ic, i0;
    int          n_fail = 0, cmp_count = 0, na, nb, k;
    initial forever #25 clk = ~clk;
    cmptmr_top #(.DIV_W(14)) dut_u (.REF_CLK(clk), .RESET(rst), .CLK_EN(en), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .EXT_COUNT_IN(ext), .MATCH_A(ma),
        .MATCH_B(mb), .IRQ(irq));
    cmptmr_src src_u (.clk(clk), .irq(irq), .pin(ext), .irq_cnt(ic));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [15:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [15:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask
    // write, then read with no gap
    task automatic wrr(input logic [15:0] a, d, b, e);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rreg(b, e);
    endtask
    // count match pulses and requests over w cycles
    task automatic win(input int w);
        na = 0;
        nb = 0;
        i0 = ic;
        repeat (w) begin
            @(negedge clk);
            na += ma;
            nb += mb;
        end
        @(posedge clk);
    endtask
    task automatic results();
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 9; k++)
            rreg(16'h5300 + 16'(2 * k), 16'h0000);
        wrr(16'h5304, 16'h1234, 16'h5304, 16'h1234);
        wrr(16'h5306, 16'h0002, 16'h5304, 16'h0000);
        wreg(16'h5300, 16'h0002);
        wrr(16'h5302, 16'h0004, 16'h5302, 16'h0004);
        // divider codes 0, 1, 2 and the reserved code
        for (k = 0; k < 4; k++) begin
            wreg(16'h5306, 16'h0000);
            wreg(16'h5308, (k < 3) ? 16'(k) : 16'h000F);
            wreg(16'h530A, (k == 1) ? 16'h0001 : 16'h0003);
            wreg(16'h5306, 16'h0003);
            repeat (20) @(posedge clk);
            win(80);
            chk(16'(nb), (k < 3) ? 16'(16 >> k) : 16'h0000);
            chk(16'(na), 16'(nb));
            chk(ic - i0, (k == 1) ? 16'(na) : 16'(na + nb));
        end
        // active compares loaded from the shadow buffers by a B match
        wreg(16'h5306, 16'h0020);
        wreg(16'h5308, 16'h0000);
        wrr(16'h5302, 16'h0009, 16'h5300, 16'h0000);
        rreg(16'h5302, 16'h0009);
        wreg(16'h5306, 16'h0021);
        repeat (30) @(posedge clk);
        win(100);
        chk(16'(nb), 16'h000A);
        chk(16'(na), 16'h000A);
        // external events with stop and resume, set up in the advised order
        wreg(16'h5306, 16'h0000);
        wreg(16'h5308, 16'h000F);
        wreg(16'h5306, 16'h0008);
        wreg(16'h5304, 16'h0100);
        wreg(16'h5302, 16'hFFFF);
        for (k = 3; k < 5; k++) begin
            wreg(16'h5306, 16'h0009);
            src_u.pulse(k);
            repeat (8) @(posedge clk);
            wreg(16'h5306, 16'h0008);
            rreg(16'h5304, (k == 3) ? 16'h0103 : 16'h0107);
        end
        // clock enable low freezes a running count
        wreg(16'h5306, 16'h0000);
        wreg(16'h5308, 16'h0000);
        wreg(16'h5306, 16'h0003);
        en <= 1'b0;
        repeat (10) @(posedge clk);
        en <= 1'b1;
        rreg(16'h5304, 16'h0001);
        results();
    end
endmodule
